// ==== bench/wscfg_host_model.sv ====
// host side of the decoded register port
`timescale 1ns/1ps
`default_nettype none
module wscfg_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic wr_o,
  output logic rd_o,
  output logic [6:0] addr_o,
  output logic [7:0] data_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 7'h00;
    data_o = 8'h00;
  end
  // bus wake left to the bus control register
  // timer is assigned to a switch before on-time is written
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    data_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    data_o = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule // wscfg_host_model
`default_nettype wire

// ==== bench/wscfg_regs_monitor.sv ====
// checker on the ports of the wake and timer configuration block
`timescale 1ns/1ps
`default_nettype none
module wscfg_regs_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // device events
  input wire logic normal_mode_i,
  input wire logic failsafe_entry_i,
  input wire logic restart_hs_clear_i,
  input wire logic status_event_i,
  input wire logic timer_b_wake_i,
  // outputs
  input wire logic wake_o,
  input wire logic int_o,
  input wire logic [2:0] wake_level_o,
  input wire logic measure_active_o,
  input wire logic bus_ctrl_force_o,
  input wire logic [4:0] bus_ctrl_force_val_o,
  input wire logic watchdog_stop_disable_hi_o,
  input wire logic timer_a_out_o
);
  logic [7:0] wi_ff, we_ff, pu_ff, fl_ff, ta_ff, rsel;
  // shadow copy of the registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wi_ff <= wscfg_pkg::RST_WK_INT;
      we_ff <= wscfg_pkg::RST_WK_EXT;
      pu_ff <= wscfg_pkg::RST_PULL;
      fl_ff <= wscfg_pkg::RST_FILT;
      ta_ff <= wscfg_pkg::RST_TMR_A;
    end else if (ce_i) begin
      if (reg_wr_i && reg_addr_i == wscfg_pkg::ADDR_WK_INT)
        wi_ff <= reg_wdata_i & wscfg_pkg::WMASK_WK_INT;
      if (reg_wr_i && reg_addr_i == wscfg_pkg::ADDR_WK_EXT)
        we_ff <= reg_wdata_i & wscfg_pkg::WMASK_WK_EXT;
      if (reg_wr_i && reg_addr_i == wscfg_pkg::ADDR_PULL)
        pu_ff <= reg_wdata_i & wscfg_pkg::WMASK_PULL;
      if (reg_wr_i && reg_addr_i == wscfg_pkg::ADDR_FILT)
        fl_ff <= reg_wdata_i & wscfg_pkg::WMASK_FILT;
      if (reg_wr_i && reg_addr_i == wscfg_pkg::ADDR_TMR_A)
        ta_ff <= reg_wdata_i & wscfg_pkg::WMASK_TMR_A;
      if (restart_hs_clear_i && (fl_ff[1] || fl_ff[3] || fl_ff[5]))
        ta_ff <= 8'h00;
      // a write in the same cycle lands before the fail-safe force
      if (failsafe_entry_i)
        we_ff <= (((reg_wr_i && reg_addr_i == wscfg_pkg::ADDR_WK_EXT) ?
                   (reg_wdata_i & wscfg_pkg::WMASK_WK_EXT) : we_ff) & wscfg_pkg::FS_EXT_KEEP)
                 | wscfg_pkg::FS_EXT_SET;
    end
  end
  always_comb begin
    case (reg_addr_i)
      wscfg_pkg::ADDR_WK_INT: rsel = wi_ff;
      wscfg_pkg::ADDR_WK_EXT: rsel = we_ff;
      wscfg_pkg::ADDR_PULL: rsel = pu_ff;
      wscfg_pkg::ADDR_FILT: rsel = fl_ff;
      wscfg_pkg::ADDR_TMR_A: rsel = ta_ff;
      default: rsel = 8'h00;
    endcase
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rd;
    ce_i && reg_rd_i |=> reg_rdata_o == $past(rsel);
  endproperty
  a_rd: assert property (p_rd) else $error("read data mismatch");
  property p_wd;
    $stable(wi_ff) |-> watchdog_stop_disable_hi_o == wi_ff[2];
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog stop bit mismatch");
  property p_int;
    int_o && !wake_o |-> $past(status_event_i && we_ff[7]);
  endproperty
  a_int: assert property (p_int) else $error("interrupt without cause");
  property p_fs;
    failsafe_entry_i |-> ##[1:2] (bus_ctrl_force_o && bus_ctrl_force_val_o == 5'h01);
  endproperty
  a_fs: assert property (p_fs) else $error("bus control force missing");
  property p_mlvl;
    we_ff[5] && $past(we_ff[5]) |-> wake_level_o[1:0] == 2'h0;
  endproperty
  a_mlvl: assert property (p_mlvl) else $error("level shown while measuring");
  property p_mact;
    measure_active_o == $past(we_ff[5] && normal_mode_i);
  endproperty
  a_mact: assert property (p_mact) else $error("measure active mismatch");
  property p_tst;
    ($stable(ta_ff) && ta_ff[6:4] inside {3'h0, 3'h6, 3'h7}) [*3]
      |-> timer_a_out_o == (ta_ff[6:4] == 3'h6);
  endproperty
  a_tst: assert property (p_tst) else $error("stopped timer level wrong");
  property p_tgo;
    ce_i && reg_wr_i && reg_addr_i == wscfg_pkg::ADDR_TMR_A && !restart_hs_clear_i
      && reg_wdata_i[6:4] inside {[3'h1:3'h5]} && reg_wdata_i[2:0] != 3'h7 |-> ##2 timer_a_out_o;
  endproperty
  a_tgo: assert property (p_tgo) else $error("timer did not start");
  property p_twb;
    timer_b_wake_i && wi_ff[7] |=> wake_o && int_o;
  endproperty
  a_twb: assert property (p_twb) else $error("timer b wake missing");
endmodule // wscfg_regs_monitor
bind wscfg_regs wscfg_regs_monitor mon_u (.*);
`default_nettype wire

// ==== bench/wscfg_regs_tb_top.sv ====
// self-checking bench for the wake and timer configuration block
`timescale 1ns/1ps
`default_nettype none
module wscfg_regs_tb_top;
  localparam int TK = 4;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, normal_mode_i = 1'b1;
  logic failsafe_entry_i = 1'b0, restart_hs_clear_i = 1'b0, status_event_i = 1'b0;
  logic timer_b_sample_i = 1'b0, timer_b_wake_i = 1'b0, reg_wr_i, reg_rd_i;
  logic wake_o, int_o, measure_active_o, bus_ctrl_force_o, watchdog_stop_disable_hi_o;
  logic timer_a_out_o;
  logic [2:0] wake_pin_i = 3'h0, wake_level_o, pull_up_o, pull_down_o, pull_auto_o;
  logic [4:0] bus_ctrl_force_val_o;
  logic [6:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  int err_count = 0, num_checks = 0;
  int ont[5] = '{1, 3, 10, 100, 200};
  int pert[6] = '{100, 200, 500, 1000, 2000, 10000};
  logic [6:0] adr[6] = '{7'h06, 7'h07, 7'h08, 7'h09, 7'h0C, 7'h0A};
  logic [7:0] rstv[6] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mskv[6] = '{8'hC4, 8'hA7, 8'h3F, 8'h3F, 8'h77, 8'h00};
  always #5 clk_i = ~clk_i;
  wscfg_regs #(.TICK_CYC(TK), .FLT_LONG_CYC(8)) dut_u (.*);
  wscfg_host_model host_u (.clk_i(clk_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
    .addr_o(reg_addr_i), .data_o(reg_wdata_i), .rdata_i(reg_rdata_o));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk("read data", 32'(e), 32'(d));
  endtask
  task automatic cnt(ref logic s, input int len, output int c);
    c = 0;
    repeat (len) begin
      c += int'(s === 1'b1);
      @(negedge clk_i);
    end
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v) begin
      if (n == lim) begin
        err_count++;
        $display("unexpected wait length: expected at most %0d seen more", lim);
        report_and_stop();
      end
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic t_regs();
    for (int k = 0; k < 6; k++) begin
      rchk(adr[k], rstv[k]);
      host_u.wr(adr[k], 8'hFF);
      rchk(adr[k], mskv[k]);
      host_u.wr(adr[k], 8'h00);
    end
  endtask
  task automatic t_pull(input logic [7:0] v, input logic [8:0] e);
    host_u.wr(7'h08, v);
    repeat (2) @(negedge clk_i);
    chk("pull decode", 32'(e), 32'({pull_up_o, pull_down_o, pull_auto_o}));
  endtask
  task automatic t_pulse(ref logic s, ref logic o, input logic [6:0] a, input logic [7:0] d,
    input int e);
    int n;
    host_u.wr(a, d);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
    cnt(o, 5, n);
    chk("pulse count", e, n);
  endtask
  task automatic t_pin(input int i, input logic [7:0] ext, input logic [7:0] flt,
    input int quiet, input int win, input int e);
    int n;
    host_u.wr(7'h07, ext);
    host_u.wr(7'h09, flt);
    for (int k = 0; k < 2; k++) begin
      wake_pin_i[i] = ~wake_pin_i[i];
      cnt(wake_o, quiet, n);
      chk("early wake", 0, n);
      cnt(wake_o, win, n);
      chk("wake count", e, n);
      chk("wake level", 32'((k == 0) && !(i < 2 && ext[5])), 32'(wake_level_o[i]));
    end
  endtask
  task automatic t_restart(input logic [7:0] flt, input logic [7:0] e);
    host_u.wr(7'h09, flt);
    host_u.wr(7'h0C, 8'h10);
    restart_hs_clear_i = 1'b1;
    @(negedge clk_i);
    restart_hs_clear_i = 1'b0;
    rchk(7'h0C, e);
    host_u.wr(7'h0C, 8'h00);
  endtask
  task automatic t_timer(input logic [2:0] on, input logic [2:0] per, input int eon,
    input int eper);
    int n, m;
    host_u.wr(7'h0C, {1'b0, on, 1'b0, per});
    wait_lvl(timer_a_out_o, 1'b1, 4, n);
    wait_lvl(timer_a_out_o, 1'b0, eon + 4, n);
    chk("on cycles", eon, n);
    if (eper > 0) begin
      wait_lvl(timer_a_out_o, 1'b1, eper, m);
      chk("period cycles", eper, n + m);
    end
    host_u.wr(7'h0C, 8'h00);
  endtask
  task automatic t_twake(input logic [7:0] wi, input int e);
    int n;
    host_u.wr(7'h06, wi);
    host_u.wr(7'h0C, 8'h10);
    cnt(wake_o, TK * 150, n);
    chk("timer wake count", e, n);
    host_u.wr(7'h0C, 8'h00);
  endtask
  task automatic t_mode();
    host_u.wr(7'h07, 8'h20);
    repeat (2) @(negedge clk_i);
    chk("measure active", 1, 32'(measure_active_o));
    normal_mode_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("measure active", 0, 32'(measure_active_o));
    normal_mode_i = 1'b1;
  endtask
  task automatic t_freeze();
    int n;
    host_u.wr(7'h0C, 8'h10);
    wait_lvl(timer_a_out_o, 1'b1, 4, n);
    ce_i = 1'b0;
    cnt(timer_a_out_o, 20, n);
    chk("frozen level", 20, n);
    ce_i = 1'b1;
    wait_lvl(timer_a_out_o, 1'b0, TK + 4, n);
    chk("on cycles after freeze", TK, n);
    host_u.wr(7'h0C, 8'h00);
  endtask
  initial begin
    int n;
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_regs();
    t_pull(8'h1B, 9'b010_100_001);
    t_pull(8'h00, 9'h000);
    host_u.wr(7'h06, 8'h04);
    repeat (2) @(negedge clk_i);
    chk("watchdog stop bit", 1, 32'(watchdog_stop_disable_hi_o));
    t_pulse(status_event_i, int_o, 7'h07, 8'h07, 0);
    t_pulse(status_event_i, int_o, 7'h07, 8'h87, 1);
    t_pulse(timer_b_wake_i, wake_o, 7'h06, 8'h80, 1);
    t_pulse(timer_b_wake_i, wake_o, 7'h06, 8'h00, 0);
    t_pulse(failsafe_entry_i, bus_ctrl_force_o, 7'h07, 8'hA0, 1);
    chk("bus control value", 32'h01, 32'(bus_ctrl_force_val_o));
    rchk(7'h07, 8'hA7);
    t_pin(0, 8'h01, 8'h00, 1595, 30, 1);
    t_pin(2, 8'h04, 8'h10, 10, 30, 1);
    t_pin(1, 8'h05, 8'h00, 0, 1630, 0);
    t_pin(0, 8'h21, 8'h00, 0, 1630, 0);
    t_mode();
    host_u.wr(7'h0C, 8'h10);
    t_pin(0, 8'h01, 8'h02, 1595, 600, 1);
    t_restart(8'h02, 8'h00);
    t_restart(8'h00, 8'h10);
    for (int k = 0; k < 5; k++) t_timer(3'(k + 1), 3'h4, TK * ont[k], 0);
    for (int k = 0; k < 6; k++) t_timer(3'h1, 3'(k), TK, TK * pert[k]);
    // on-time beyond period, then stopped with output high
    for (int k = 0; k < 2; k++) begin
      host_u.wr(7'h0C, k ? 8'h60 : 8'h50);
      repeat (2) @(negedge clk_i);
      cnt(timer_a_out_o, 900, n);
      chk("held high", 900, n);
    end
    t_twake(8'h40, 1);
    t_twake(8'h00, 0);
    t_freeze();
    report_and_stop();
  end
endmodule // wscfg_regs_tb_top
`default_nettype wire

// ==== rtl/wscfg_cyc_timer.sv ====
// cyclic timer: on-time and period counted in fixed ticks
`timescale 1ns/1ps
`default_nettype none
module wscfg_cyc_timer #(
  parameter int unsigned TICK_CYC = wscfg_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // settings
  input wire logic [2:0] on_code_i,
  input wire logic [2:0] per_code_i,
  input wire logic start_i,
  // timer events
  output logic out_o,
  output logic sample_o,
  output logic period_o
);
  typedef struct packed {
    logic [15:0] pre;
    logic [14:0] tick;
    logic run;
    logic out;
    logic samp;
    logic per;
  } wscfg_tmr_s;
  wscfg_tmr_s st_ff, nxt_st;
  logic running_code;

  if (TICK_CYC < 2 || TICK_CYC > 65535) begin : g_chk
    $error("TICK_CYC out of range");
  end

  function automatic logic [14:0] on_ticks(input logic [2:0] c);
    case (c)
      3'h1: on_ticks = 15'(wscfg_pkg::ON_T1_US / wscfg_pkg::TICK_US);
      3'h2: on_ticks = 15'(wscfg_pkg::ON_T2_US / wscfg_pkg::TICK_US);
      3'h3: on_ticks = 15'(wscfg_pkg::ON_T3_US / wscfg_pkg::TICK_US);
      3'h4: on_ticks = 15'(wscfg_pkg::ON_T4_US / wscfg_pkg::TICK_US);
      3'h5: on_ticks = 15'(wscfg_pkg::ON_T5_US / wscfg_pkg::TICK_US);
      default: on_ticks = 15'h0000;
    endcase
  endfunction

  function automatic logic [14:0] per_ticks(input logic [2:0] c);
    case (c)
      3'h0: per_ticks = 15'(wscfg_pkg::PER_P0_MS * 1000 / wscfg_pkg::TICK_US);
      3'h1: per_ticks = 15'(wscfg_pkg::PER_P1_MS * 1000 / wscfg_pkg::TICK_US);
      3'h2: per_ticks = 15'(wscfg_pkg::PER_P2_MS * 1000 / wscfg_pkg::TICK_US);
      3'h3: per_ticks = 15'(wscfg_pkg::PER_P3_MS * 1000 / wscfg_pkg::TICK_US);
      3'h4: per_ticks = 15'(wscfg_pkg::PER_P4_MS * 1000 / wscfg_pkg::TICK_US);
      3'h5: per_ticks = 15'(wscfg_pkg::PER_P5_MS * 1000 / wscfg_pkg::TICK_US);
      3'h6: per_ticks = 15'(wscfg_pkg::PER_P6_MS * 1000 / wscfg_pkg::TICK_US);
      default: per_ticks = 15'h0000;
    endcase
  endfunction

  assign running_code = (on_ticks(on_code_i) != 15'h0000) &&
                        (per_code_i != wscfg_pkg::PER_RESERVED);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.samp = 1'b0;
    nxt_st.per = 1'b0;
    if (!running_code) begin
      // stopped: level follows the static on-time code
      nxt_st = '0;
      nxt_st.out = (on_code_i == wscfg_pkg::ON_OFF_HIGH);
    end else if (start_i) begin
      nxt_st.run = 1'b1;
      nxt_st.pre = '0;
      nxt_st.tick = '0;
      nxt_st.out = 1'b1;
    end else if (st_ff.run) begin
      if (st_ff.pre == 16'(TICK_CYC - 1)) begin
        nxt_st.pre = '0;
        nxt_st.tick = st_ff.tick + 15'h0001;
        if (st_ff.tick + 15'h0001 == on_ticks(on_code_i)) begin
          nxt_st.out = 1'b0;
          nxt_st.samp = 1'b1;
        end
        if (st_ff.tick + 15'h0001 == per_ticks(per_code_i)) begin
          nxt_st.tick = '0;
          nxt_st.out = 1'b1;
          nxt_st.per = 1'b1;
        end
      end else begin
        nxt_st.pre = st_ff.pre + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign out_o = st_ff.out;
  assign sample_o = st_ff.samp;
  assign period_o = st_ff.per;
endmodule // wscfg_cyc_timer
`default_nettype wire

// ==== rtl/wscfg_pkg.sv ====
// constants for the wake source and cyclic timer configuration block
package wscfg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [6:0] ADDR_WK_INT = 7'h06;
  localparam logic [6:0] ADDR_WK_EXT = 7'h07;
  localparam logic [6:0] ADDR_PULL = 7'h08;
  localparam logic [6:0] ADDR_FILT = 7'h09;
  localparam logic [6:0] ADDR_TMR_A = 7'h0C;
  localparam logic [7:0] RST_WK_INT = 8'h00;
  localparam logic [7:0] RST_WK_EXT = 8'h07;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_FILT = 8'h00;
  localparam logic [7:0] RST_TMR_A = 8'h00;
  localparam logic [7:0] WMASK_WK_INT = 8'hC4;
  localparam logic [7:0] WMASK_WK_EXT = 8'hA7;
  localparam logic [7:0] WMASK_PULL = 8'h3F;
  localparam logic [7:0] WMASK_FILT = 8'h3F;
  localparam logic [7:0] WMASK_TMR_A = 8'h77;
  localparam int unsigned BIT_TMR_B_WK = 7;
  localparam int unsigned BIT_TMR_A_WK = 6;
  localparam int unsigned BIT_WD_STOP_HI = 2;
  localparam int unsigned BIT_INT_GLOBAL = 7;
  localparam int unsigned BIT_MEAS = 5;
  localparam int unsigned BIT_ON_LSB = 4;
  localparam int unsigned BIT_PER_LSB = 0;
  localparam logic [7:0] FS_EXT_KEEP = 8'hA0;
  localparam logic [7:0] FS_EXT_SET = 8'h07;
  localparam logic [4:0] FS_BUS_VAL = 5'h01;
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_A = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_B = 2'h3;
  localparam logic [2:0] ON_OFF_LOW = 3'h0;
  localparam logic [2:0] ON_OFF_HIGH = 3'h6;
  localparam logic [2:0] ON_RESERVED = 3'h7;
  localparam logic [2:0] PER_RESERVED = 3'h7;
  localparam int unsigned FLT_SHORT_US = 16;
  localparam int unsigned FLT_LONG_US = 64;
  localparam int unsigned FLT_SHORT_CYC = FLT_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned FLT_LONG_CYC = FLT_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned ON_T1_US = 100;
  localparam int unsigned ON_T2_US = 300;
  localparam int unsigned ON_T3_US = 1000;
  localparam int unsigned ON_T4_US = 10000;
  localparam int unsigned ON_T5_US = 20000;
  localparam int unsigned PER_P0_MS = 10;
  localparam int unsigned PER_P1_MS = 20;
  localparam int unsigned PER_P2_MS = 50;
  localparam int unsigned PER_P3_MS = 100;
  localparam int unsigned PER_P4_MS = 200;
  localparam int unsigned PER_P5_MS = 1000;
  localparam int unsigned PER_P6_MS = 2000;
endpackage

// ==== rtl/wscfg_regs.sv ====
// wake source and cyclic timer A configuration registers with their logic
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// R1 - timer B wake enabled by bit 7
// R2 - timer A wake enabled by bit 6
// R3 - bit 2 requests watchdog off in stop
// R4 - reserved bits always read zero
// R5 - global bit widens interrupt to all status
// R6 - measure select disables wake inputs a, b
// R7 - bits 2..0 enable wake inputs c..a
// R8 - measurement runs in normal; levels a,b ignored
// R9 - host selects bus wake via bus control
// R10 - fail-safe forces wake registers to defaults; code only sets wk_ext bits 2..0, keeps bits 7 and 5, leaves wk_int
// R11 - two-bit pull code per wake input
// R12 - static filter codes 16us and 64us
// R13 - cyclic codes sample at on-time end
// R14 - host assigns timer to a switch
// R15 - on-time field codes and durations
// R16 - period field codes and durations
// R17 - running on-time write starts timer
// R18 - restart switch clear also clears timer; code only clears it when a filter code is cyclic
// R19 - cyclic sensing and timer wake coexist
// R20 - writes to reserved bits are dropped
module wscfg_regs #(
  parameter int unsigned TICK_CYC = wscfg_pkg::TICK_CYC,
  parameter int unsigned FLT_LONG_CYC = wscfg_pkg::FLT_LONG_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // register access from the serial frame decoder
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // device state
  input wire logic normal_mode_i,
  input wire logic failsafe_entry_i,
  input wire logic restart_hs_clear_i,
  input wire logic status_event_i,
  // timer B, kept elsewhere
  input wire logic timer_b_sample_i,
  input wire logic timer_b_wake_i,
  // wake pins
  input wire logic [2:0] wake_pin_i,
  // wake and interrupt
  output logic wake_o,
  output logic int_o,
  output logic [2:0] wake_level_o,
  output logic measure_active_o,
  // bus control force on fail-safe
  output logic bus_ctrl_force_o,
  output logic [4:0] bus_ctrl_force_val_o,
  // pad and watchdog controls
  output logic [2:0] pull_up_o,
  output logic [2:0] pull_down_o,
  output logic [2:0] pull_auto_o,
  output logic watchdog_stop_disable_hi_o,
  // timer A
  output logic timer_a_out_o
);
  typedef struct packed {
    logic [7:0] wk_int;
    logic [7:0] wk_ext;
    logic [7:0] pull;
    logic [7:0] filt;
    logic [7:0] tmr_a;
    logic tmr_start;
    logic [7:0] rdata;
    logic wake;
    logic irq;
    logic [2:0] lvl;
    logic meas_act;
    logic bus_force;
    logic [2:0] p_up;
    logic [2:0] p_dn;
    logic [2:0] p_auto;
  } wscfg_regs_s;

  localparam wscfg_regs_s RST_ST = '{
    wk_int: wscfg_pkg::RST_WK_INT,
    wk_ext: wscfg_pkg::RST_WK_EXT,
    pull: wscfg_pkg::RST_PULL,
    filt: wscfg_pkg::RST_FILT,
    tmr_a: wscfg_pkg::RST_TMR_A,
    default: '0
  };

  wscfg_regs_s st_ff, nxt_st;
  logic [2:0] flt_lvl;
  logic [2:0] flt_chg;
  logic tmr_a_samp;
  logic tmr_a_per;
  logic [2:0] in_wake;
  logic tmr_wake;
  logic any_wake;
  logic meas_sel;

  function automatic logic [7:0] rd_mux(input wscfg_regs_s s, input logic [6:0] a);
    case (a)
      wscfg_pkg::ADDR_WK_INT: rd_mux = s.wk_int;
      wscfg_pkg::ADDR_WK_EXT: rd_mux = s.wk_ext;
      wscfg_pkg::ADDR_PULL: rd_mux = s.pull;
      wscfg_pkg::ADDR_FILT: rd_mux = s.filt;
      wscfg_pkg::ADDR_TMR_A: rd_mux = s.tmr_a;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  function automatic logic is_cyclic(input logic [1:0] c);
    is_cyclic = (c == wscfg_pkg::FLT_CYCLIC_A) || (c == wscfg_pkg::FLT_CYCLIC_B);
  endfunction

  function automatic logic is_running_on(input logic [2:0] c);
    is_running_on = (c != wscfg_pkg::ON_OFF_LOW) && (c != wscfg_pkg::ON_OFF_HIGH) &&
                    (c != wscfg_pkg::ON_RESERVED);
  endfunction

  // R15 R16 timer A decode and counting
  wscfg_cyc_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_tmr_a (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .on_code_i(st_ff.tmr_a[wscfg_pkg::BIT_ON_LSB +: 3]),
    .per_code_i(st_ff.tmr_a[wscfg_pkg::BIT_PER_LSB +: 3]),
    .start_i(st_ff.tmr_start),
    .out_o(timer_a_out_o),
    .sample_o(tmr_a_samp),
    .period_o(tmr_a_per)
  );

  // R12 R13 static or cyclic filter per input
  for (genvar i = 0; i < 3; i++) begin : g_in
    wscfg_wake_filt #(
      .LONG_CYC(FLT_LONG_CYC)
    ) u_filt (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .pin_i(wake_pin_i[i]),
      .cfg_i(st_ff.filt[2*i +: 2]),
      .samp_a_i(tmr_a_samp),
      .samp_b_i(timer_b_sample_i),
      .lvl_o(flt_lvl[i]),
      .chg_o(flt_chg[i])
    );
  end

  assign meas_sel = st_ff.wk_ext[wscfg_pkg::BIT_MEAS];

  // R6 R7 per-input enables, inputs a and b gated by measure select
  assign in_wake[0] = flt_chg[0] & st_ff.wk_ext[0] & ~meas_sel;
  assign in_wake[1] = flt_chg[1] & st_ff.wk_ext[1] & ~meas_sel;
  assign in_wake[2] = flt_chg[2] & st_ff.wk_ext[2];

  // R1 R2 R19 timer wakes run beside cyclic sensing
  assign tmr_wake = (tmr_a_per & st_ff.wk_int[wscfg_pkg::BIT_TMR_A_WK]) |
                    (timer_b_wake_i & st_ff.wk_int[wscfg_pkg::BIT_TMR_B_WK]);
  assign any_wake = (|in_wake) | tmr_wake;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tmr_start = 1'b0;
    nxt_st.bus_force = 1'b0;
    if (reg_wr_i) begin
      // R4 R20 reserved bits masked on write
      case (reg_addr_i)
        wscfg_pkg::ADDR_WK_INT: nxt_st.wk_int = reg_wdata_i & wscfg_pkg::WMASK_WK_INT;
        wscfg_pkg::ADDR_WK_EXT: nxt_st.wk_ext = reg_wdata_i & wscfg_pkg::WMASK_WK_EXT;
        wscfg_pkg::ADDR_PULL: nxt_st.pull = reg_wdata_i & wscfg_pkg::WMASK_PULL;
        wscfg_pkg::ADDR_FILT: nxt_st.filt = reg_wdata_i & wscfg_pkg::WMASK_FILT;
        wscfg_pkg::ADDR_TMR_A: begin
          nxt_st.tmr_a = reg_wdata_i & wscfg_pkg::WMASK_TMR_A;
          // R17 running on-time starts the timer
          nxt_st.tmr_start = is_running_on(reg_wdata_i[wscfg_pkg::BIT_ON_LSB +: 3]);
        end
        default: nxt_st.tmr_start = 1'b0;
      endcase
    end
    // R18 clear timer when cyclic sensing in use
    if (restart_hs_clear_i &&
        (is_cyclic(st_ff.filt[1:0]) || is_cyclic(st_ff.filt[3:2]) ||
         is_cyclic(st_ff.filt[5:4]))) begin
      nxt_st.tmr_a = 8'h00;
      nxt_st.tmr_start = 1'b0;
    end
    // R10 fail-safe entry restores wake sources
    if (failsafe_entry_i) begin
      nxt_st.wk_ext = (nxt_st.wk_ext & wscfg_pkg::FS_EXT_KEEP) | wscfg_pkg::FS_EXT_SET;
      nxt_st.bus_force = 1'b1;
    end
    // R4 unmapped and reserved read as zero
    if (reg_rd_i) begin
      nxt_st.rdata = rd_mux(st_ff, reg_addr_i);
    end
    nxt_st.wake = any_wake;
    // R5 global scope widens the interrupt
    nxt_st.irq = any_wake | (st_ff.wk_ext[wscfg_pkg::BIT_INT_GLOBAL] & status_event_i);
    // R8 measurement in normal mode, levels a,b hidden
    nxt_st.meas_act = meas_sel & normal_mode_i;
    nxt_st.lvl = {flt_lvl[2], meas_sel ? 2'b00 : flt_lvl[1:0]};
    // R11 pull code decode per input
    for (int i = 0; i < 3; i++) begin
      nxt_st.p_up[i] = (nxt_st.pull[2*i +: 2] == wscfg_pkg::PULL_UP);
      nxt_st.p_dn[i] = (nxt_st.pull[2*i +: 2] == wscfg_pkg::PULL_DOWN);
      nxt_st.p_auto[i] = (nxt_st.pull[2*i +: 2] == wscfg_pkg::PULL_AUTO);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= RST_ST;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;
  assign wake_o = st_ff.wake;
  assign int_o = st_ff.irq;
  assign wake_level_o = st_ff.lvl;
  assign measure_active_o = st_ff.meas_act;
  assign bus_ctrl_force_o = st_ff.bus_force;
  assign bus_ctrl_force_val_o = wscfg_pkg::FS_BUS_VAL;
  assign pull_up_o = st_ff.p_up;
  assign pull_down_o = st_ff.p_dn;
  assign pull_auto_o = st_ff.p_auto;
  // R3 watchdog stop-mode request bit
  assign watchdog_stop_disable_hi_o = st_ff.wk_int[wscfg_pkg::BIT_WD_STOP_HI];
endmodule // wscfg_regs
`default_nettype wire

// ==== rtl/wscfg_wake_filt.sv ====
// one wake input: synchroniser, static or cyclic filter, change event
`timescale 1ns/1ps
`default_nettype none
module wscfg_wake_filt #(
  parameter int unsigned LONG_CYC = wscfg_pkg::FLT_LONG_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // pin and settings
  input wire logic pin_i,
  input wire logic [1:0] cfg_i,
  input wire logic samp_a_i,
  input wire logic samp_b_i,
  // filtered level and change event
  output logic lvl_o,
  output logic chg_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic raw;
    logic [15:0] cnt;
    logic lvl;
    logic chg;
  } wscfg_flt_s;
  wscfg_flt_s st_ff, nxt_st;
  logic [15:0] thr_m1;
  logic take;

  if (LONG_CYC < 1 || LONG_CYC > 65535) begin : g_chk
    $error("LONG_CYC out of range");
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.chg = 1'b0;
    nxt_st.s1 = pin_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.raw = st_ff.s2;
    if (st_ff.s2 != st_ff.raw) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt != 16'hFFFF) begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
    thr_m1 = 16'(wscfg_pkg::FLT_SHORT_CYC - 1);
    take = 1'b1;
    case (cfg_i)
      // R12 static filters
      wscfg_pkg::FLT_STATIC_SHORT: take = 1'b1;
      wscfg_pkg::FLT_STATIC_LONG: thr_m1 = 16'(LONG_CYC - 1);
      // R13 sampled at end of on-time
      wscfg_pkg::FLT_CYCLIC_A: take = samp_a_i;
      wscfg_pkg::FLT_CYCLIC_B: take = samp_b_i;
      default: take = 1'b0;
    endcase
    if (take && st_ff.cnt >= thr_m1 && st_ff.raw != st_ff.lvl) begin
      nxt_st.lvl = st_ff.raw;
      nxt_st.chg = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign lvl_o = st_ff.lvl;
  assign chg_o = st_ff.chg;
endmodule // wscfg_wake_filt
`default_nettype wire
